// file: dcf_regs.vh
// Register map, field positions, reset values and timing figures of the
// dual-clock flag FIFO.
// Assumes the includer runs on one 100 ns system clock.
`ifndef DCF_REGS_VH
`define DCF_REGS_VH

// Register byte offsets on the Avalon-MM slave.
`define DCF_REG_STATUS   5'h00
`define DCF_REG_EMPTYOFS 5'h04
`define DCF_REG_FULLOFS  5'h08
`define DCF_REG_IRQSTAT  5'h0c
`define DCF_REG_IRQMASK  5'h10

// Status register fields.
`define DCF_ST_EMPTY_N   0
`define DCF_ST_FULL_N    1
`define DCF_ST_AEMPTY_N  2
`define DCF_ST_AFULL_N   3
`define DCF_ST_TWO_WE    4
`define DCF_ST_IN_RST    5

// Interrupt status and mask fields.
`define DCF_IRQ_FULL     0
`define DCF_IRQ_EMPTY    1
`define DCF_IRQ_OVER     2
`define DCF_IRQ_UNDER    3
`define DCF_IRQ_W        4

// Reset values.
`define DCF_EOFS_RST     14'h0007
`define DCF_FOFS_RST     14'h0007
`define DCF_MASK_RST     4'h0

// Timing figures in nanoseconds.
`define DCF_CLK_NS       100
`define DCF_SKEW1_NS     5
`define DCF_SKEW2_NS     10

`endif

// file: dcf_sync2.v
// Two-flop synchroniser for a bus of independent pin levels.
// Assumes each bit is a slow level; no bit-to-bit coherence is promised.
`timescale 1ns/1ns
`default_nettype none

module dcf_sync2 #(
  parameter W = 1
) (
  // Clock and reset.
  input  wire         clk,
  input  wire         rst_n,
  // Levels in and out.
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // The first stage feeds only the second one, never any logic.
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule
`default_nettype wire

// file: dcf_pdly.v
// Delay line that shows a pointer to the far side a fixed number of cycles
// late, standing in for the clock-to-clock skew window.
// Assumes N is at least one.
`timescale 1ns/1ns
`default_nettype none

module dcf_pdly #(
  parameter W = 15,
  parameter N = 1
) (
  // Clock and reset.
  input  wire         clk,
  input  wire         rst_n,
  // Pointer in and delayed copy out.
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);

  wire [W-1:0] tap [0:N];

  assign tap[0] = din;

  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_stage
      reg [W-1:0] stage_ff;
      // Each stage adds one cycle of skew.
      always @(posedge clk) begin
        if (!rst_n) begin
          stage_ff <= {W{1'b0}};
        end else begin
          stage_ff <= tap[i];
        end
      end
      assign tap[i+1] = stage_ff;
    end
  endgenerate

  assign dout = tap[N];

endmodule
`default_nettype wire

// file: dcf_fifo.v
// Dual-clock 9-bit FIFO with full, empty and programmable almost flags.
// The write and read clocks arrive as pins and are sampled on MCLK; each
// of their rising edges becomes a one-cycle enable. Offsets and interrupts
// are reached over an Avalon-MM slave with waitrequest.
// Assumes the pin clocks run well below MCLK/4 so no edge is missed.
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "dcf_regs.vh"

// Contract
// - Full releases on write edge after skew1
// - Empty releases on read edge after skew1
// - Almost-empty changes on read edge after skew2
// - Almost-full changes on write edge after skew2
// - Free-running clocks tolerated during reset
// - After reset outputs low, or released
// - Dual pin level at reset picks role
// - First word readable cycle after empty release
// - Latency applies only at empty boundary
// - Latency one period, two when skew short
// - Empty low when no unread words
// - Full low when every location used
// - Almost-empty low at or below n
// - Almost-full high only when free exceeds m
module dcf_fifo #(
  parameter ADDR_W = 14
) (
  // System clock and reset.
  input  wire        MCLK,
  input  wire        RSTN,
  // Write side pins.
  input  wire        WRITE_CLOCK,
  input  wire        WRITE_ENABLE_PRIMARY_N,
  input  wire        DUAL_MODE_ENABLE_PIN,
  input  wire [8:0]  DATA_IN,
  // Read side pins.
  input  wire        READ_CLOCK,
  input  wire        READ_ENABLE_A_N,
  input  wire        READ_ENABLE_B_N,
  input  wire        OUTPUT_ENABLE_N,
  output reg  [8:0]  DATA_OUT,
  output reg         DATA_OUT_OE,
  // Device reset pin.
  input  wire        RESET_N,
  // Flags.
  output reg         EMPTY_FLAG_N,
  output reg         FULL_FLAG_N,
  output reg         ALMOST_EMPTY_FLAG_N,
  output reg         ALMOST_FULL_FLAG_N,
  // Avalon-MM slave.
  input  wire [4:0]  AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  // Interrupt.
  output reg         IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Constants.

  localparam PW = ADDR_W + 1;
  localparam integer SK1_RAW = (`DCF_SKEW1_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS;
  localparam integer SK2_RAW = (`DCF_SKEW2_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS;
  localparam integer SKEW1_CYC = (SK1_RAW < 1) ? 1 : SK1_RAW;
  localparam integer SKEW2_CYC = (SK2_RAW < 1) ? 1 : SK2_RAW;
  localparam [PW-1:0] DEPTH_V = {1'b1, {ADDR_W{1'b0}}};
  localparam [PW-1:0] PTR_ONE = {{ADDR_W{1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  wire [16:0] pin_raw;
  wire [16:0] pin_s;

  assign pin_raw = {DATA_IN, WRITE_CLOCK, READ_CLOCK, ~RESET_N,
                    WRITE_ENABLE_PRIMARY_N, DUAL_MODE_ENABLE_PIN,
                    READ_ENABLE_A_N, READ_ENABLE_B_N, ~OUTPUT_ENABLE_N};

  dcf_sync2 #(
    .W (17)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RSTN),
    .din   (pin_raw),
    .dout  (pin_s)
  );

  wire [8:0] s_data;
  wire       s_wclk;
  wire       s_rclk;
  wire       s_rst_n;
  wire       s_write_enable_primary_n;
  wire       s_dual;
  wire       s_rena_n;
  wire       s_renb_n;
  wire       s_oe_n;

  assign s_data   = pin_s[16:8];
  assign s_wclk   = pin_s[7];
  assign s_rclk   = pin_s[6];
  assign s_rst_n  = ~pin_s[5]; // Carried inverted, so a cleared stage is no pin reset.
  assign s_write_enable_primary_n = pin_s[4];
  assign s_dual   = pin_s[3];
  assign s_rena_n = pin_s[2];
  assign s_renb_n = pin_s[1];
  assign s_oe_n   = ~pin_s[0]; // Carried inverted, so a cleared stage keeps outputs off.

  reg wclk_d_ff;
  reg rclk_d_ff;

  // Previous synchronised clock levels, for rising-edge detection.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      wclk_d_ff <= 1'b0;
      rclk_d_ff <= 1'b0;
    end else begin
      wclk_d_ff <= s_wclk;
      rclk_d_ff <= s_rclk;
    end
  end

  wire w_edge;
  wire r_edge;
  wire in_rst;

  assign w_edge = s_wclk & ~wclk_d_ff;
  assign r_edge = s_rclk & ~rclk_d_ff;
  assign in_rst = ~s_rst_n;

  ////////////////////////////////////////////////////////////////////////
  // Mode capture, storage and pointers.

  reg [8:0]    mem [0:(1<<ADDR_W)-1];
  reg [PW-1:0] wr_ptr_ff;
  reg [PW-1:0] rd_ptr_ff;
  reg          two_we_ff;
  reg [13:0]   eofs_ff;
  reg [13:0]   fofs_ff;

  wire ld_active;
  wire wr_try;
  wire rd_try;
  wire do_wr;
  wire do_rd;

  // With the load role taken, a low dual pin blocks both data directions.
  assign ld_active = ~two_we_ff & ~s_dual;
  assign wr_try = w_edge & ~in_rst & ~s_write_enable_primary_n & s_dual;
  assign rd_try = r_edge & ~in_rst & ~s_rena_n & ~s_renb_n & ~ld_active;
  assign do_wr  = wr_try & FULL_FLAG_N;
  assign do_rd  = rd_try & EMPTY_FLAG_N;

  // The pin level is followed all through reset and the last value held.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      two_we_ff <= 1'b1;
    end else if (in_rst) begin
      two_we_ff <= s_dual;
    end
  end

  // Array write; no reset because the contents are undefined until written.
  always @(posedge MCLK) begin
    if (do_wr) begin
      mem[wr_ptr_ff[ADDR_W-1:0]] <= s_data;
    end
  end

  wire [PW-1:0] nxt_wr_ptr;
  wire [PW-1:0] nxt_rd_ptr;

  assign nxt_wr_ptr = do_wr ? wr_ptr_ff + PTR_ONE : wr_ptr_ff;
  assign nxt_rd_ptr = do_rd ? rd_ptr_ff + PTR_ONE : rd_ptr_ff;

  // Pointers; edges seen during the device reset are simply ignored.
  always @(posedge MCLK) begin
    if (!RSTN || in_rst) begin
      wr_ptr_ff <= {PW{1'b0}};
      rd_ptr_ff <= {PW{1'b0}};
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Skewed views of the far pointer.

  wire [PW-1:0] rd_seen1;
  wire [PW-1:0] rd_seen2;
  wire [PW-1:0] wr_seen1;
  wire [PW-1:0] wr_seen2;

  // A far edge closer than the skew window is not yet visible, so the
  // flag moves one edge later, as the real part may.
  dcf_pdly #(.W (PW), .N (SKEW1_CYC)) u_rd1 (
    .clk (MCLK), .rst_n (RSTN), .din (rd_ptr_ff), .dout (rd_seen1)
  );
  dcf_pdly #(.W (PW), .N (SKEW2_CYC)) u_rd2 (
    .clk (MCLK), .rst_n (RSTN), .din (rd_ptr_ff), .dout (rd_seen2)
  );
  dcf_pdly #(.W (PW), .N (SKEW1_CYC)) u_wr1 (
    .clk (MCLK), .rst_n (RSTN), .din (wr_ptr_ff), .dout (wr_seen1)
  );
  dcf_pdly #(.W (PW), .N (SKEW2_CYC)) u_wr2 (
    .clk (MCLK), .rst_n (RSTN), .din (wr_ptr_ff), .dout (wr_seen2)
  );

  wire [PW-1:0] wcnt1;
  wire [PW-1:0] wcnt2;
  wire [PW-1:0] wfree2;
  wire [PW-1:0] rcnt1;
  wire [PW-1:0] rcnt2;

  // Word counts as each side sees them; wrap is handled by the extra bit.
  assign wcnt1  = nxt_wr_ptr - rd_seen1;
  assign wcnt2  = nxt_wr_ptr - rd_seen2;
  assign wfree2 = DEPTH_V - wcnt2;
  assign rcnt1  = wr_seen1 - nxt_rd_ptr;
  assign rcnt2  = wr_seen2 - nxt_rd_ptr;

  ////////////////////////////////////////////////////////////////////////
  // Flags, each moved only on its own side's clock edge.

  wire full_hit;
  wire empty_hit;

  assign full_hit  = (wcnt1 == DEPTH_V);
  assign empty_hit = (rcnt1 == {PW{1'b0}});

  // Write side flags.
  always @(posedge MCLK) begin
    if (!RSTN || in_rst) begin
      FULL_FLAG_N        <= 1'b1;
      ALMOST_FULL_FLAG_N <= 1'b1;
    end else if (w_edge) begin
      FULL_FLAG_N        <= ~full_hit;
      ALMOST_FULL_FLAG_N <= (wfree2 > {1'b0, fofs_ff});
    end
  end

  // Read side flags; a write onto an empty FIFO is seen here only after
  // the skew delay, which sets the first-word latency.
  always @(posedge MCLK) begin
    if (!RSTN || in_rst) begin
      EMPTY_FLAG_N        <= 1'b0;
      ALMOST_EMPTY_FLAG_N <= 1'b0;
    end else if (r_edge) begin
      EMPTY_FLAG_N        <= ~empty_hit;
      ALMOST_EMPTY_FLAG_N <= (rcnt2 > {1'b0, eofs_ff});
    end
  end

  // Output register; a read needs the empty flag already released, so the
  // first word appears one read edge after the release.
  always @(posedge MCLK) begin
    if (!RSTN || in_rst) begin
      DATA_OUT <= 9'h000;
    end else if (do_rd) begin
      DATA_OUT <= mem[rd_ptr_ff[ADDR_W-1:0]];
    end
  end

  // Drive enable follows the output-enable pin, also during reset.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      DATA_OUT_OE <= 1'b0;
    end else begin
      DATA_OUT_OE <= ~s_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt events.

  reg                 full_d_ff;
  reg                 empty_d_ff;
  reg [`DCF_IRQ_W-1:0] irq_stat_ff;
  reg [`DCF_IRQ_W-1:0] irq_mask_ff;

  wire [`DCF_IRQ_W-1:0] irq_ev;

  // Falling flags mark the full and empty events; refused strobes mark
  // overflow and underflow.
  assign irq_ev = {rd_try & ~EMPTY_FLAG_N, wr_try & ~FULL_FLAG_N,
                   empty_d_ff & ~EMPTY_FLAG_N, full_d_ff & ~FULL_FLAG_N};

  always @(posedge MCLK) begin
    if (!RSTN) begin
      full_d_ff  <= 1'b1;
      empty_d_ff <= 1'b0;
    end else begin
      full_d_ff  <= FULL_FLAG_N;
      empty_d_ff <= EMPTY_FLAG_N;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave.

  wire                  acc;
  wire                  wr_acc;
  wire [`DCF_IRQ_W-1:0] w1c;

  // Every request is held one cycle with waitrequest high, then accepted.
  assign acc    = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
  assign wr_acc = AVS_WRITE & ~AVS_WAITREQUEST;
  assign w1c    = (wr_acc && AVS_ADDRESS == `DCF_REG_IRQSTAT) ?
                  AVS_WRITEDATA[`DCF_IRQ_W-1:0] : {`DCF_IRQ_W{1'b0}};

  // Waitrequest drops for exactly one cycle per request.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      AVS_WAITREQUEST <= 1'b1;
    end else if ((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Read data is loaded while waitrequest is high, so it stands during
  // the accepting cycle. Unmapped offsets read as zero.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      AVS_READDATA <= 32'h00000000;
    end else if (AVS_READ & AVS_WAITREQUEST) begin
      case (AVS_ADDRESS)
        `DCF_REG_STATUS:
          AVS_READDATA <= {26'h0000000, in_rst, two_we_ff,
                           ALMOST_FULL_FLAG_N, ALMOST_EMPTY_FLAG_N,
                           FULL_FLAG_N, EMPTY_FLAG_N};
        `DCF_REG_EMPTYOFS: AVS_READDATA <= {18'h00000, eofs_ff};
        `DCF_REG_FULLOFS:  AVS_READDATA <= {18'h00000, fofs_ff};
        `DCF_REG_IRQSTAT:  AVS_READDATA <= {28'h0000000, irq_stat_ff};
        `DCF_REG_IRQMASK:  AVS_READDATA <= {28'h0000000, irq_mask_ff};
        default:           AVS_READDATA <= 32'h00000000;
      endcase
    end
  end

  // Writable registers take effect at the accepting edge.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      eofs_ff     <= `DCF_EOFS_RST;
      fofs_ff     <= `DCF_FOFS_RST;
      irq_mask_ff <= `DCF_MASK_RST;
    end else if (wr_acc) begin
      if (AVS_ADDRESS == `DCF_REG_EMPTYOFS) begin
        eofs_ff <= AVS_WRITEDATA[13:0];
      end
      if (AVS_ADDRESS == `DCF_REG_FULLOFS) begin
        fofs_ff <= AVS_WRITEDATA[13:0];
      end
      if (AVS_ADDRESS == `DCF_REG_IRQMASK) begin
        irq_mask_ff <= AVS_WRITEDATA[`DCF_IRQ_W-1:0];
      end
    end
  end

  // Sticky status: a new event in the clearing cycle survives the clear.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      irq_stat_ff <= {`DCF_IRQ_W{1'b0}};
      IRQ         <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~w1c) | irq_ev;
      IRQ         <= |(((irq_stat_ff & ~w1c) | irq_ev) & irq_mask_ff);
    end
  end

  // The acc term is kept for readability of the handshake above.
  wire unused_acc;
  assign unused_acc = acc;

endmodule
`default_nettype wire

// file: dcf_fifo_checker.sv
// Concurrent checks on the top ports of the dual-clock flag FIFO.
// Assumes one MCLK domain with synchronous active-low RSTN.
`timescale 1ns/1ns
`default_nettype none
module dcf_fifo_checker (
  // Clock and resets.
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic RESET_N,
  // Pin clocks and output enable.
  input wire logic WRITE_CLOCK,
  input wire logic READ_CLOCK,
  input wire logic OUTPUT_ENABLE_N,
  // Outputs watched.
  input wire logic DATA_OUT_OE,
  input wire logic EMPTY_FLAG_N,
  input wire logic FULL_FLAG_N,
  input wire logic ALMOST_EMPTY_FLAG_N,
  input wire logic ALMOST_FULL_FLAG_N
);
  logic       wclk_ff, rclk_ff;
  logic [3:0] wage_ff, rage_ff;
  ////////////////////////////////////////////////////////////////////////
  // Cycles since each pin clock rose; saturates so a paused clock never wraps.
  always @(posedge MCLK) begin
    wclk_ff <= WRITE_CLOCK;
    rclk_ff <= READ_CLOCK;
    if (!RSTN) begin
      wage_ff <= 4'hf;
      rage_ff <= 4'hf;
    end else begin
      wage_ff <= (WRITE_CLOCK && !wclk_ff) ? 4'h0 : wage_ff + {3'h0, wage_ff != 4'hf};
      rage_ff <= (READ_CLOCK && !rclk_ff) ? 4'h0 : rage_ff + {3'h0, rage_ff != 4'hf};
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  empty_edge_a:
    assert property ($changed(EMPTY_FLAG_N) && RESET_N && $past(RESET_N, 4) |-> rage_ff <= 4'h6)
      else $error("Empty flag moved away from a read edge.");
  aempty_edge_a:
    assert property ($changed(ALMOST_EMPTY_FLAG_N) && RESET_N && $past(RESET_N, 4)
      |-> rage_ff <= 4'h6) else $error("Almost-empty flag moved away from a read edge.");
  full_edge_a:
    assert property ($changed(FULL_FLAG_N) && RESET_N && $past(RESET_N, 4) |-> wage_ff <= 4'h6)
      else $error("Full flag moved away from a write edge.");
  afull_edge_a:
    assert property ($changed(ALMOST_FULL_FLAG_N) && RESET_N && $past(RESET_N, 4)
      |-> wage_ff <= 4'h6) else $error("Almost-full flag moved away from a write edge.");
  empty_nest_a:
    assert property (!EMPTY_FLAG_N |-> !ALMOST_EMPTY_FLAG_N)
      else $error("Empty without almost-empty.");
  full_nest_a:
    assert property (!FULL_FLAG_N |-> !ALMOST_FULL_FLAG_N && EMPTY_FLAG_N)
      else $error("Full without almost-full, or full and empty together.");
  reset_flags_a:
    assert property (disable iff (1'b0) !RSTN |=> !EMPTY_FLAG_N && FULL_FLAG_N
      && !ALMOST_EMPTY_FLAG_N && ALMOST_FULL_FLAG_N) else $error("Flags wrong in reset.");
  oe_delay_a:
    assert property (RESET_N && $past(RESET_N, 4) && $past(RSTN, 3)
      |-> DATA_OUT_OE == !$past(OUTPUT_ENABLE_N, 3)) else $error("Output enable lag wrong.");
endmodule
bind dcf_fifo dcf_fifo_checker dcf_fifo_checker_inst (
  .MCLK(MCLK), .RSTN(RSTN), .RESET_N(RESET_N), .WRITE_CLOCK(WRITE_CLOCK),
  .READ_CLOCK(READ_CLOCK), .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .DATA_OUT_OE(DATA_OUT_OE),
  .EMPTY_FLAG_N(EMPTY_FLAG_N), .FULL_FLAG_N(FULL_FLAG_N),
  .ALMOST_EMPTY_FLAG_N(ALMOST_EMPTY_FLAG_N), .ALMOST_FULL_FLAG_N(ALMOST_FULL_FLAG_N));
`default_nettype wire

// file: dcf_pin_partner.sv
// Writer and reader logic on the FIFO pins, with clocks divided from MCLK.
// Assumes MCLK at 10 MHz; write clock 8 cycles, read clock 10 cycles.
`timescale 1ns/1ns
`default_nettype none
module dcf_pin_partner (
  // Clock, resets and commands.
  input  wire logic       MCLK,
  input  wire logic       RSTN,
  input  wire logic       RESET_N,
  input  wire logic       wr_go,
  input  wire logic       rd_go,
  // Pins toward the FIFO.
  output var  logic       write_clock,
  output var  logic       read_clock,
  output var  logic       we_n,
  output var  logic       re_n,
  output var  logic [8:0] wdata,
  // Edge counts for the bench.
  output var  int         wr_edges,
  output var  int         rd_edges
);
  logic [3:0] wph_ff, rph_ff;
  logic [2:0] quiet_ff;
  logic       rst_ff;
  ////////////////////////////////////////////////////////////////////////
  // Clocks run on through device reset, then pause a few cycles after its
  // release so no edge lands while the reset synchroniser is still clearing.
  always @(posedge MCLK) begin
    if (!RSTN) begin
      {wph_ff, rph_ff, quiet_ff, write_clock, read_clock, wdata} <= '0;
      {we_n, re_n, rst_ff} <= 3'h7;
      wr_edges <= 0;
      rd_edges <= 0;
    end else begin
      rst_ff <= RESET_N;
      if (RESET_N && !rst_ff) begin
        quiet_ff <= 3'h7;
      end else if (quiet_ff != 3'h0) begin
        quiet_ff <= quiet_ff - 3'h1;
      end else begin
        wph_ff <= (wph_ff == 4'h7) ? 4'h0 : wph_ff + 4'h1;
        rph_ff <= (rph_ff == 4'h9) ? 4'h0 : rph_ff + 4'h1;
        write_clock <= (wph_ff == 4'h7) || (wph_ff < 4'h3);
        read_clock <= (rph_ff == 4'h9) || (rph_ff < 4'h4);
        if (wph_ff == 4'h7 && !we_n) wr_edges <= wr_edges + 1;
        if (rph_ff == 4'h9 && !re_n) rd_edges <= rd_edges + 1;
        if (wph_ff == 4'h3) begin
          we_n <= !wr_go; // Enables and data move on the falling edge.
          wdata <= wr_edges[8:0];
        end
        if (rph_ff == 4'h4) re_n <= !rd_go;
      end
    end
  end
endmodule
`default_nettype wire

// file: dcf_fifo_tb.sv
// Self-checking bench for the flag FIFO: register tasks and pin traffic.
// Assumes the pin partner and the bound checker are compiled beside it.
`timescale 1ns/1ns
`default_nettype none
`include "dcf_regs.vh"
module dcf_fifo_tb;
  logic        mclk, rstn, reset_n, dual, oe_n, wr_go, rd_go, avs_rd, avs_wr;
  logic        wclk, rclk, we_n, re_n, e_n, f_n, ae_n, af_n, oe, wreq, irq;
  logic [4:0]  avs_addr;
  logic [8:0]  wdata, dout;
  logic [31:0] avs_wdata, avs_rdata, got;
  int          wr_edges, rd_edges, fails, total_checks, w, n, i;
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  dcf_fifo #(.ADDR_W(4)) dcf_fifo_inst (.MCLK(mclk), .RSTN(rstn), .WRITE_CLOCK(wclk),
    .WRITE_ENABLE_PRIMARY_N(we_n), .DUAL_MODE_ENABLE_PIN(dual), .DATA_IN(wdata),
    .READ_CLOCK(rclk), .READ_ENABLE_A_N(re_n), .READ_ENABLE_B_N(re_n),
    .OUTPUT_ENABLE_N(oe_n), .DATA_OUT(dout), .DATA_OUT_OE(oe), .RESET_N(reset_n),
    .EMPTY_FLAG_N(e_n), .FULL_FLAG_N(f_n), .ALMOST_EMPTY_FLAG_N(ae_n),
    .ALMOST_FULL_FLAG_N(af_n), .AVS_ADDRESS(avs_addr), .AVS_READ(avs_rd),
    .AVS_WRITE(avs_wr), .AVS_WRITEDATA(avs_wdata), .AVS_READDATA(avs_rdata),
    .AVS_WAITREQUEST(wreq), .IRQ(irq));
  dcf_pin_partner dcf_pin_partner_inst (.MCLK(mclk), .RSTN(rstn), .RESET_N(reset_n),
    .wr_go(wr_go), .rd_go(rd_go), .write_clock(wclk), .read_clock(rclk), .we_n(we_n),
    .re_n(re_n), .wdata(wdata), .wr_edges(wr_edges), .rd_edges(rd_edges));
  ////////////////////////////////////////////////////////////////////////
  // Shared compare, wait and bus tasks.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hung(input string nm);
    fails++;
    $display("mismatch %s expected done seen timeout", nm);
    print_verdict;
  endtask
  // Holds the request until waitrequest is sampled low, then releases it.
  task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_addr <= a;
    avs_wdata <= d;
    avs_rd <= !wr;
    avs_wr <= wr;
    do begin
      @(posedge mclk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    if (wreq !== 1'b0) hung("bus");
    got = avs_rdata;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] exp);
    avs(1'b0, a, 32'h0);
    check(nm, got, exp);
  endtask
  task automatic wr_words(input int c);
    int t, k;
    t = wr_edges + c;
    wr_go <= 1'b1;
    for (k = 0; k < 20 * c && wr_edges < t; k++) @(posedge mclk);
    if (wr_edges < t) hung("write");
    wr_go <= 1'b0;
  endtask
  // The dual pin level is held steady across the whole device reset.
  task automatic pin_reset(input logic d);
    dual <= d;
    tick(2);
    reset_n <= 1'b0;
    tick(6);
    reset_n <= 1'b1;
    tick(14);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, reset_n, dual, oe_n, wr_go, rd_go, avs_rd, avs_wr} = 8'h70;
    {avs_addr, avs_wdata, fails, total_checks} = '0;
    tick(5);
    rstn <= 1'b1;
    tick(2);
    check("reset flags", {e_n, f_n, ae_n, af_n}, 4'h5);
    check("reset dout", dout, 9'h000);
    rd_chk("status", `DCF_REG_STATUS, 32'h1a);
    rd_chk("empty offset", `DCF_REG_EMPTYOFS, 32'h7);
    rd_chk("full offset", `DCF_REG_FULLOFS, 32'h7);
    rd_chk("mask", `DCF_REG_IRQMASK, 32'h0);
    avs(1'b1, 5'h14, 32'hffff);
    rd_chk("unmapped", 5'h14, 32'h0);
    $display("test reset values done");
    wr_words(8);
    tick(16);
    check("fill 8", {e_n, f_n, ae_n, af_n}, 4'hf);
    wr_words(1);
    tick(16);
    check("fill 9", {e_n, f_n, ae_n, af_n}, 4'he);
    wr_words(7);
    tick(16);
    check("fill 16", {e_n, f_n, ae_n, af_n}, 4'ha);
    wr_words(1);
    tick(4);
    check("irq masked", irq, 1'b0);
    avs(1'b1, `DCF_REG_IRQMASK, 32'hc);
    tick(3);
    check("irq overflow", irq, 1'b1);
    avs(1'b1, `DCF_REG_IRQSTAT, 32'h4);
    tick(3);
    check("irq cleared", irq, 1'b0);
    $display("test fill done");
    rd_go <= 1'b1;
    for (n = 0; n < 16; n++) begin
      w = rd_edges;
      for (i = 0; i < 30 && rd_edges == w; i++) @(posedge mclk);
      if (rd_edges == w) hung("read");
      tick(6);
      check("read word", dout, n[8:0]);
    end
    rd_go <= 1'b0;
    tick(20);
    check("drained", {e_n, f_n, ae_n, af_n}, 4'h5);
    check("irq underflow", irq, 1'b1);
    rd_chk("irq status", `DCF_REG_IRQSTAT, 32'hb);
    avs(1'b1, `DCF_REG_IRQSTAT, 32'hf);
    tick(3);
    check("irq cleared", irq, 1'b0);
    $display("test drain done");
    rd_go <= 1'b1;
    w = wr_edges;
    wr_words(1);
    for (i = 0; i < 60 && e_n !== 1'b1; i++) @(posedge mclk);
    if (e_n !== 1'b1) hung("empty release");
    check("word at release", dout, 9'h00f);
    for (i = 0; i < 30 && dout !== w[8:0]; i++) @(posedge mclk);
    if (dout !== w[8:0]) hung("first word");
    check("first word latency", i >= 4 && i <= 16, 1'b1);
    rd_go <= 1'b0;
    tick(20);
    $display("test first word done");
    wr_words(3);
    pin_reset(1'b0);
    check("pin reset flags", {e_n, f_n, ae_n, af_n}, 4'h5);
    check("pin reset dout", dout, 9'h000);
    rd_chk("load role", `DCF_REG_STATUS, 32'h0a);
    wr_words(1);
    tick(24);
    check("load blocks write", e_n, 1'b0);
    pin_reset(1'b1);
    rd_chk("two enables", `DCF_REG_STATUS, 32'h1a);
    oe_n <= 1'b1;
    tick(5);
    check("outputs released", oe, 1'b0);
    oe_n <= 1'b0;
    tick(5);
    check("outputs driven", oe, 1'b1);
    $display("test pin reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
